// File: inc/and_cmp_pkg.sv
// constants for the and / compare-branch execution block
// assumes a byte-wide core with 16-bit program counter
package and_cmp_pkg;
  // opcodes
  localparam logic [7:0] OP_AND_DIR_IMM = 8'h53;
  localparam logic [7:0] OP_AND_C_BIT   = 8'h82;
  localparam logic [7:0] OP_AND_C_NBIT  = 8'hB0;
  localparam logic [7:0] OP_CMP_A_DIR   = 8'hB5;
  localparam logic [7:0] OP_CMP_A_IMM   = 8'hB4;
  localparam logic [6:0] OP_CMP_IND     = 7'h5B;  // 1011_011i
  localparam logic [4:0] OP_CMP_REG     = 5'h17;  // 1011_1rrr
  // instruction lengths in bytes
  localparam logic [15:0] LEN_BIT = 16'h0002;
  localparam logic [15:0] LEN_3   = 16'h0003;
  // reset values
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_WRITE = 2'b10
  } exec_state_t;

  typedef enum logic [1:0] {
    K_AND_BYTE = 2'b00,
    K_AND_BIT  = 2'b01,
    K_CMP      = 2'b10
  } kind_t;
endpackage : and_cmp_pkg

// File: design/and_compare_jump_exec.sv
// execution of byte and, carry and, and compare-branch-unequal
// assumes the core fetches all instruction bytes and presents them
// with instr_valid, and supplies the operand values it has read
// Functional notes
// [RULE1] byte and immediate: 3 bytes, 2 cycles
// [RULE2] carry cleared when source bit zero
// [RULE3] complemented form inverts operand, bit unchanged
// [RULE4] carry and touches only the carry
// [RULE5] bit source only by direct bit address
// [RULE6] 82h plus bit address: carry and bit
// [RULE7] B0h plus bit address: carry and not bit
// [RULE8] branch only when operands differ
// [RULE9] target is next pc plus signed offset
// [RULE10] carry set when first below second
// [RULE11] compared operands are never written
// [RULE12] four compare operand combinations supported
// [RULE13] port operand read from output latch
// [RULE14] port read-and-write completes within instruction
module and_compare_jump_exec (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand1,
  input  wire logic [7:0]  operand2,
  input  wire logic [15:0] pc_in,
  input  wire logic        carry_in,
  input  wire logic [7:0]  acc_in,
  input  wire logic [7:0]  direct_latch_data,
  input  wire logic [7:0]  indirect_data,
  input  wire logic [7:0]  reg_data,
  input  wire logic        bit_data,
  output logic             busy,
  output logic             done,
  output logic             unknown_op,
  output logic [7:0]       direct_addr,
  output logic             direct_rd,
  output logic [7:0]       bit_addr,
  output logic             bit_rd,
  output logic             direct_we,
  output logic [7:0]       direct_wdata,
  output logic             carry_we,
  output logic             carry_out,
  output logic             pc_we,
  output logic [15:0]      pc_out
);

  typedef struct packed {
    and_cmp_pkg::exec_state_t st;
    and_cmp_pkg::kind_t       kind;
    logic [7:0]               op;
    logic [7:0]               b1;
    logic [7:0]               b2;
    logic [15:0]              pc;
    logic                     busy;
    logic                     done;
    logic                     unknown_op;
    logic [7:0]               direct_addr;
    logic                     direct_rd;
    logic [7:0]               bit_addr;
    logic                     bit_rd;
    logic                     direct_we;
    logic [7:0]               direct_wdata;
    logic                     carry_we;
    logic                     carry_out;
    logic                     pc_we;
    logic [15:0]              pc_out;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [7:0]  cmp_a;
  logic [7:0]  cmp_b;
  logic        src_bit;
  logic [15:0] next_pc;
  logic [15:0] offset_ext;

  // opcode decode, offered and held
  logic        dec_and_byte;
  logic        dec_and_bit;
  logic        dec_and_nbit;
  logic        dec_cmp_dir;
  logic        dec_cmp_imm;
  logic        dec_cmp_ind;
  logic        dec_cmp_reg;
  logic        dec_cmp;
  logic        dec_known;
  logic        held_cmp_dir;
  logic        held_cmp_ind;
  logic        held_cmp_reg;
  logic        held_nbit;

  // operand results
  logic [7:0]  and_result;
  logic        bit_result;
  logic        cmp_less;
  logic        cmp_differ;
  logic [15:0] cmp_target;
  logic [15:0] seq_pc_and;
  logic [15:0] seq_pc_bit;

  // --------------------------------------------------------------
  // decode of the opcode offered with instr_valid
  // --------------------------------------------------------------
  // only these patterns are claimed; anything else is refused with a
  // one-cycle unknown_op pulse so the core can hand it elsewhere
  always_comb begin
    dec_and_byte = (opcode == and_cmp_pkg::OP_AND_DIR_IMM); // [RULE1]
    dec_and_bit  = (opcode == and_cmp_pkg::OP_AND_C_BIT); // [RULE6]
    dec_and_nbit = (opcode == and_cmp_pkg::OP_AND_C_NBIT); // [RULE7]
    dec_cmp_dir  = (opcode == and_cmp_pkg::OP_CMP_A_DIR);
    dec_cmp_imm  = (opcode == and_cmp_pkg::OP_CMP_A_IMM);
    dec_cmp_ind  = (opcode[7:1] == and_cmp_pkg::OP_CMP_IND);
    dec_cmp_reg  = (opcode[7:3] == and_cmp_pkg::OP_CMP_REG);
    dec_cmp      = dec_cmp_dir | dec_cmp_imm | dec_cmp_ind |
                   dec_cmp_reg; // [RULE12]
    dec_known    = dec_and_byte | dec_and_bit | dec_and_nbit |
                   dec_cmp;
  end

  // --------------------------------------------------------------
  // decode of the held opcode in the execute cycle
  // --------------------------------------------------------------
  // the offered opcode may already belong to the next instruction,
  // so the execute cycle only ever looks at the held copy
  always_comb begin
    held_cmp_dir = (s_q.op == and_cmp_pkg::OP_CMP_A_DIR);
    held_cmp_ind = (s_q.op[7:1] == and_cmp_pkg::OP_CMP_IND);
    held_cmp_reg = (s_q.op[7:3] == and_cmp_pkg::OP_CMP_REG);
    held_nbit    = (s_q.op == and_cmp_pkg::OP_AND_C_NBIT);
  end

  // --------------------------------------------------------------
  // operand selection
  // --------------------------------------------------------------
  always_comb begin
    cmp_a = acc_in;
    cmp_b = s_q.b1;
    // accumulator against a direct byte reads the latch side too
    if (held_cmp_dir) begin // [RULE12]
      cmp_b = direct_latch_data;
    end else if (held_cmp_ind) begin
      cmp_a = indirect_data; // [RULE12]
    end else if (held_cmp_reg) begin
      cmp_a = reg_data; // [RULE12]
    end
    // slash form: operand inverted, stored bit never written
    src_bit = held_nbit ?
              ~bit_data : bit_data; // [RULE3]
    next_pc = s_q.pc + and_cmp_pkg::LEN_3; // [RULE9]
    offset_ext = {{8{s_q.b2[7]}}, s_q.b2}; // [RULE9]
  end

  // --------------------------------------------------------------
  // results, from the held instruction bytes and the operands sampled in the execute cycle
  // --------------------------------------------------------------
  always_comb begin
    // latch value, not pins, so an input level cannot leak in
    and_result = direct_latch_data & s_q.b2; // [RULE13]
    // carry can only be kept or cleared here, never set
    bit_result = carry_in & src_bit; // [RULE2]
    cmp_less   = (cmp_a < cmp_b); // [RULE10]
    cmp_differ = (cmp_a != cmp_b); // [RULE8]
    // offset counts from the following instruction, not the opcode
    cmp_target = cmp_differ ?
                 next_pc + offset_ext : next_pc; // [RULE9]
    seq_pc_and = s_q.pc + and_cmp_pkg::LEN_3; // [RULE1]
    seq_pc_bit = s_q.pc + and_cmp_pkg::LEN_BIT; // [RULE6]
  end

  // --------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------
  // the done cycle is already idle, so a new request can be taken
  // back to back with no dead cycle in between
  always_comb begin
    s_d = s_q;
    s_d.done       = 1'b0;
    s_d.unknown_op = 1'b0;
    s_d.direct_rd  = 1'b0;
    s_d.bit_rd     = 1'b0;
    s_d.direct_we  = 1'b0;
    s_d.carry_we   = 1'b0;
    s_d.pc_we      = 1'b0;
    case (s_q.st)
      and_cmp_pkg::ST_IDLE: begin
        if (instr_valid && !dec_known) begin
          // refused: only the pulse, no address or state is disturbed
          s_d.unknown_op = 1'b1;
        end else if (instr_valid) begin
          s_d.op          = opcode;
          s_d.b1          = operand1;
          s_d.b2          = operand2;
          s_d.pc          = pc_in;
          s_d.st          = and_cmp_pkg::ST_EXEC;
          s_d.busy        = 1'b1;
          s_d.direct_addr = operand1;
          s_d.bit_addr    = operand1; // [RULE5]
          if (dec_and_byte) begin // [RULE1]
            s_d.kind      = and_cmp_pkg::K_AND_BYTE;
            s_d.direct_rd = 1'b1;
          end else if (dec_and_bit || dec_and_nbit) begin
            s_d.kind   = and_cmp_pkg::K_AND_BIT; // [RULE6] [RULE7]
            s_d.bit_rd = 1'b1;
          end else begin
            s_d.kind      = and_cmp_pkg::K_CMP;
            s_d.direct_rd = dec_cmp_dir;
          end
        end
      end
      and_cmp_pkg::ST_EXEC: begin
        // second cycle of every instruction here
        s_d.st = and_cmp_pkg::ST_IDLE;
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.pc_we = 1'b1;
        case (s_q.kind)
          and_cmp_pkg::K_AND_BYTE: begin
            // latch value, not pins; read and write in one instruction
            s_d.direct_we = 1'b1; // [RULE14]
            s_d.direct_wdata = and_result; // [RULE13]
            s_d.pc_out = seq_pc_and; // [RULE1]
          end
          and_cmp_pkg::K_AND_BIT: begin
            // only the carry is written; no other flag strobe exists
            s_d.carry_we = 1'b1; // [RULE4]
            s_d.carry_out = bit_result; // [RULE2]
            s_d.pc_out = seq_pc_bit; // [RULE6]
          end
          and_cmp_pkg::K_CMP: begin
            // operands are only read, never written back
            s_d.direct_we = 1'b0; // [RULE11]
            s_d.carry_we = 1'b1;
            s_d.carry_out = cmp_less; // [RULE10]
            // equal operands fall through to the next instruction
            s_d.pc_out = cmp_target; // [RULE8]
          end
          default: begin
            s_d.pc_out = s_q.pc;
          end
        endcase
      end
      default: begin
        s_d.st = and_cmp_pkg::ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------
  // state register
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // field by field so every multi-bit reset value is a named constant
      s_q.st           <= and_cmp_pkg::ST_IDLE;
      s_q.kind         <= and_cmp_pkg::K_AND_BYTE;
      s_q.op           <= and_cmp_pkg::BYTE_RST;
      s_q.b1           <= and_cmp_pkg::BYTE_RST;
      s_q.b2           <= and_cmp_pkg::BYTE_RST;
      s_q.pc           <= and_cmp_pkg::PC_RST;
      s_q.busy         <= 1'b0;
      s_q.done         <= 1'b0;
      s_q.unknown_op   <= 1'b0;
      s_q.direct_addr  <= and_cmp_pkg::BYTE_RST;
      s_q.direct_rd    <= 1'b0;
      s_q.bit_addr     <= and_cmp_pkg::BYTE_RST;
      s_q.bit_rd       <= 1'b0;
      s_q.direct_we    <= 1'b0;
      s_q.direct_wdata <= and_cmp_pkg::BYTE_RST;
      s_q.carry_we     <= 1'b0;
      s_q.carry_out    <= 1'b0;
      s_q.pc_we        <= 1'b0;
      s_q.pc_out       <= and_cmp_pkg::PC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // every output is a field of s_q, so no path is combinational
  assign busy         = s_q.busy;
  assign done         = s_q.done;
  assign unknown_op   = s_q.unknown_op;
  assign direct_addr  = s_q.direct_addr;
  assign direct_rd    = s_q.direct_rd;
  assign bit_addr     = s_q.bit_addr;
  assign bit_rd       = s_q.bit_rd;
  assign direct_we    = s_q.direct_we;
  assign direct_wdata = s_q.direct_wdata;
  assign carry_we     = s_q.carry_we;
  assign carry_out    = s_q.carry_out;
  assign pc_we        = s_q.pc_we;
  assign pc_out       = s_q.pc_out;

endmodule : and_compare_jump_exec

// File: sim/and_cmp_props.sv
// checker for the and / compare-branch execution block
// assumes binding to the execution block and_compare_jump_exec, ports matched by name
module and_cmp_props (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       instr_valid,
  input wire logic       busy,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand2,
  input wire logic [7:0] operand1,
  input wire logic [7:0] acc_in,
  input wire logic       carry_in,
  input wire logic       bit_data,
  input wire logic [7:0] direct_latch_data,
  input wire logic       done,
  input wire logic       direct_we,
  input wire logic [7:0] direct_wdata,
  input wire logic       carry_we,
  input wire logic       carry_out,
  input wire logic       pc_we,
  input wire logic       bit_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // request is only taken while idle
  wire go = instr_valid && !busy;
  and_byte_done_a: assert property (go && opcode == 8'h53 |->
    ##2 done && direct_we) else $error("byte and late");
  and_byte_data_a: assert property (direct_we |-> direct_wdata ==
    ($past(direct_latch_data) & $past(operand2, 2))) else $error("bad and");
  bit_and_a: assert property (go && opcode == 8'h82 |-> ##2 carry_we &&
    carry_out == ($past(carry_in) & $past(bit_data))) else $error("c and");
  bit_and_not_a: assert property (go && opcode == 8'hB0 |-> ##2 carry_we &&
    carry_out == ($past(carry_in) & ~$past(bit_data))) else $error("c nand");
  carry_only_a: assert property (carry_we |-> !direct_we)
    else $error("byte written with carry");
  bit_src_a: assert property (bit_rd |->
    $past(opcode) inside {8'h82, 8'hB0}) else $error("bit read");
  done_once_a: assert property (done |=> !done)
    else $error("done too long");
  pc_with_done_a: assert property (done |-> pc_we)
    else $error("pc not written");
  cmp_carry_a: assert property (go && opcode == 8'hB4 |->
    ##2 carry_we && carry_out == ($past(acc_in) < $past(operand1, 2)))
    else $error("compare carry wrong");
endmodule : and_cmp_props
bind and_compare_jump_exec and_cmp_props i_props (.*);

// File: sim/and_compare_jump_exec_tb.sv
// testbench for the and / compare-branch execution block
// assumes package, design and checker are compiled first
module and_compare_jump_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset, instr_valid, carry_in, bit_data;
  logic [7:0]  opcode, operand1, operand2, acc_in, direct_latch_data;
  logic [7:0]  indirect_data, reg_data, direct_addr, bit_addr, direct_wdata;
  logic        busy, done, unknown_op, direct_rd, bit_rd, direct_we;
  logic        carry_we, carry_out, pc_we;
  logic [15:0] pc_in, pc_out;
  int          bad_count = 0;
  int          checked = 0;
  and_compare_jump_exec i_dut (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task print_verdict;
    if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // one instruction; d feeds the latch, indirect and register sources so one table fits all
  task run(input logic [7:0] op, o1, o2, a, d);
    @(posedge clk_sys);
    {instr_valid, opcode, operand1, operand2} <= {1'b1, op, o1, o2};
    {acc_in, carry_in, bit_data} <= {a, a[0], d[0]};
    {direct_latch_data, indirect_data, reg_data} <= {d, d, d};
    pc_in <= pc_in + 16'h0010;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    cmp(busy, 1'b1);
    cmp(direct_rd, 16'(op == 8'h53 || op == 8'hB5));
    cmp(bit_rd, 16'(op == 8'h82 || op == 8'hB0));
    @(posedge clk_sys);
    #1;
    cmp(done, 1'b1);
    cmp(pc_we, 1'b1);
    cmp(carry_we, 16'(op != 8'h53));
    cmp(busy, 1'b0);
  endtask : run
  task t_and_byte;
    run(8'h53, 8'h90, 8'h55, 8'h00, 8'hC3);
    cmp(direct_we, 1'b1);
    cmp(direct_wdata, 8'h41);
    cmp(direct_addr, 8'h90);
    cmp(pc_out, pc_in + 16'h0003);
  endtask : t_and_byte
  task t_bit_and;
    for (int i = 0; i < 8; i++) begin
      run(i[2] ? 8'hB0 : 8'h82, 8'hA7, 8'h00, 8'(i[1]), 8'(i[0]));
      cmp(carry_out, 16'(i[1] & (i[0] ^ i[2])));
      cmp(bit_addr, 8'hA7);
      cmp(pc_out, pc_in + 16'h0002);
      cmp(direct_we, 1'b0);
    end
  endtask : t_bit_and
  // opcode outside the block: pulse only, direct_addr untouched
  task t_refused;
    @(posedge clk_sys);
    {instr_valid, opcode, operand1} <= {1'b1, 8'hA5, 8'h3C};
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    cmp(unknown_op, 1'b1);
    cmp(busy, 1'b0);
    cmp(direct_addr, 8'hA7);
    @(posedge clk_sys);
    #1;
    cmp(unknown_op, 1'b0);
    cmp(done, 1'b0);
  endtask : t_refused
  task t_compare;
    logic [7:0] ops [4] = '{8'hB5, 8'hB4, 8'hB6, 8'hBF};
    logic [7:0] f;
    for (int k = 0; k < 12; k++) begin
      f = 8'h5F + 8'(k % 3);
      if (k < 3) run(ops[0], 8'h30, 8'hF0, f, 8'h60);
      else if (k < 6) run(ops[1], 8'h60, 8'hF0, f, 8'h00);
      else run(ops[k / 3], 8'h60, 8'hF0, 8'h00, f);
      cmp(carry_out, 16'(k % 3 == 0));
      cmp(pc_out, pc_in + ((k % 3 == 1) ? 16'h0003 : 16'hFFF3));
      cmp(direct_we, 1'b0);
    end
  endtask : t_compare
  initial begin
    {instr_valid, carry_in, bit_data, opcode, operand1, operand2} = '0;
    {acc_in, direct_latch_data, indirect_data, reg_data, pc_in} = '0;
    reset = 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_and_byte;
    t_bit_and;
    t_refused;
    t_compare;
    print_verdict;
  end
  // about 86 cycles expected; allow well over that
  initial begin
    #2000;
    bad_count++;
    print_verdict;
  end
endmodule : and_compare_jump_exec_tb
